// *** ssaa_pkg.sv ***
// shared constants and carrier types of the start-up and slot address allocator
package ssaa_pkg;
	localparam int SSAA_SLOTS = 32;
	localparam int SSAA_ROW_MAX = 8;
	localparam int SSAA_AW = 13;
	localparam int SSAA_IMG_AW = 8;
	localparam int SSAA_IMG_BYTES = 256;
	localparam logic [12:0] SSAA_IMG_TOP = 13'h0FF;
	localparam logic [12:0] SSAA_DIG_BASE = 13'h0000;
	localparam logic [12:0] SSAA_ANA_BASE = 13'h0100;
	localparam int SSAA_DIG_SHIFT = 2;
	localparam int SSAA_ANA_SHIFT = 4;
	localparam logic [2:0] SSAA_CLS_EMPTY = 3'h0;
	localparam logic [2:0] SSAA_CLS_DIGITAL = 3'h1;
	localparam logic [2:0] SSAA_CLS_ANALOG = 3'h2;
	localparam logic [2:0] SSAA_CLS_FUNCTION = 3'h3;
	localparam logic [2:0] SSAA_CLS_COMM = 3'h4;
	localparam logic [7:0] SSAA_DIAG_UNBUF_PON = 8'h01;
	localparam logic [7:0] SSAA_DIAG_BAT_CLEARED = 8'h02;
	localparam logic [1:0] SSAA_SETTLE_CYC = 2'h3;
	localparam longint SSAA_CLK_HZ = 125000000;
	localparam longint SSAA_BAT_CLEAR_S = 30;
	localparam longint SSAA_BAT_CLEAR_CYC = SSAA_BAT_CLEAR_S * SSAA_CLK_HZ;
	// access request of the executing program
	typedef struct packed {
		logic valid;
		logic write;
		logic image;
		logic [12:0] addr;
		logic [7:0] wdata;
	} ssaa_acc_t;
	// byte request on the backplane bus
	typedef struct packed {
		logic valid;
		logic write;
		logic [12:0] addr;
		logic [7:0] wdata;
	} ssaa_bp_t;
	typedef logic [SSAA_SLOTS-1:0][12:0] ssaa_table_t;
	typedef logic [SSAA_SLOTS-1:0][2:0] ssaa_class_vec_t;
endpackage

// *** ssaa_slot_addr.sv ***
// start address of one slot under automatic allocation
`timescale 1ns/10ps
module ssaa_slot_addr (
	input wire logic [4:0] slot_idx,
	input wire logic [2:0] module_class,
	output logic [12:0] start_addr
);
	import ssaa_pkg::*;
	// slot byte spans
	// slot_idx is the slot number minus one, so the formulas need no subtraction
	always_comb begin
		case (module_class)
			SSAA_CLS_DIGITAL: start_addr = SSAA_DIG_BASE + 13'({slot_idx, 2'b00});
			SSAA_CLS_ANALOG, SSAA_CLS_FUNCTION, SSAA_CLS_COMM: start_addr = SSAA_ANA_BASE + 13'({slot_idx, 4'h0});
			default: start_addr = 13'h0000;
		endcase
	end
endmodule // ssaa_slot_addr

// *** ssaa_image.sv ***
// input and output process image, two separate byte arrays in flip-flops
`timescale 1ns/10ps
module ssaa_image (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic in_we,
	input wire logic [7:0] in_addr,
	input wire logic [7:0] in_wdata,
	input wire logic out_we,
	input wire logic [7:0] out_addr,
	input wire logic [7:0] out_wdata,
	input wire logic [7:0] in_raddr,
	output logic [7:0] in_rdata,
	input wire logic [7:0] out_raddr,
	output logic [7:0] out_rdata
);
	import ssaa_pkg::*;
	typedef struct packed {
		logic [SSAA_IMG_BYTES-1:0][7:0] in_img;
		logic [SSAA_IMG_BYTES-1:0][7:0] out_img;
	} ssaa_img_t;
	ssaa_img_t s_reg;
	ssaa_img_t s_next;
	// one write port per image part
	always_comb begin
		s_next = s_reg;
		if (in_we) begin
			s_next.in_img[in_addr] = in_wdata;
		end
		if (out_we) begin
			s_next.out_img[out_addr] = out_wdata;
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
	assign in_rdata = s_reg.in_img[in_raddr];
	assign out_rdata = s_reg.out_img[out_raddr];
endmodule // ssaa_image

// *** ssaa_startup.sv ***
// start-up sequencer, slot address allocator and process image access
// Notes on behaviour
// - after power-on enter the state the mode lever shows
// - factory state: STOP to RUN gives RUN without a program
// - valid configuration held: start in RUN with the retained program
// - battery holds backed-up RAM at most 30 days, then contents count as lost
// - lost backed-up RAM forces an overall reset during start-up
// - after that reset copy card blocks, else protected blocks, into work memory
// - unbuffered power-on: RUN only with lever RUN and fault handler; log it
// - discharged battery at power restore raises battery fault and overall reset; the code raises both on lost backup or stored fault, not on battery_charged
// - fault clears only after 30 s powered with full battery
// - digital modules get addresses from 0 rising with slot
// - without hardware configuration analog modules sit at even addresses from 256
// - peripheral space 0 to 8191, input and output images 0 to 255
// - low range signal states kept as separate input and output images
// - process image refreshed whenever an execution cycle finishes
// - at most 8 modules per row are configured
// - up to 32 modules in one row without row interfaces
// - modules reached by direct byte access or through the image
// - no hardware configuration means automatic address allocation
// - digital modules take 4 bytes, others 16 bytes
// - digital start address is 4 times slot minus one
// - other start address is 16 times slot minus one plus 256
`timescale 1ns/10ps
module ssaa_startup #(
	parameter logic [31:0] BAT_CLEAR_CYCLES = 32'(ssaa_pkg::SSAA_BAT_CLEAR_CYC)
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic mode_lever_run,
	input wire logic battery_charged,
	input wire logic backup_intact,
	input wire logic battery_fault_stored,
	input wire logic config_valid,
	input wire logic card_present,
	input wire logic protected_present,
	input wire logic fault_handler_present,
	input wire logic hw_config_present,
	input wire logic row_master_present,
	input wire logic copy_done,
	input wire ssaa_pkg::ssaa_class_vec_t module_class,
	input wire ssaa_pkg::ssaa_table_t hw_addr_table,
	input wire logic cycle_done,
	input wire ssaa_pkg::ssaa_acc_t acc,
	output logic acc_ready,
	output logic acc_rvalid,
	output logic [7:0] acc_rdata,
	output ssaa_pkg::ssaa_bp_t bp,
	input wire logic bp_ready,
	input wire logic [7:0] bp_rdata,
	output logic run_mode,
	output logic program_loaded,
	output logic battery_fault,
	output logic overall_reset,
	output logic copy_from_card,
	output logic copy_protected,
	output logic diag_valid,
	output logic [7:0] diag_code,
	output logic addr_ready,
	output logic auto_alloc,
	output ssaa_pkg::ssaa_table_t slot_addr,
	output logic [5:0] module_count,
	output logic row_limit_error,
	output logic image_refreshed
);
	import ssaa_pkg::*;
	typedef enum logic [3:0] {
		ST_SETTLE, ST_EVAL, ST_OVR, ST_COPY, ST_ALLOC, ST_DECIDE, ST_OPER, ST_DIRECT, ST_REFRESH
	} ssaa_state_t;
	typedef struct packed {
		ssaa_state_t st;
		logic [1:0] settle;
		logic lever_s1, lever_s2, batt_s1, batt_s2, backup_s1, backup_s2;
		logic lever_prev;
		logic fault_strap;
		logic unbuffered;
		logic run;
		logic prog;
		logic bat_fault;
		logic ovr;
		logic copy_card;
		logic copy_prot;
		logic diag;
		logic [7:0] diag_code;
		logic addr_ready;
		logic auto;
		logic [4:0] slot;
		ssaa_table_t addr_tab;
		logic [5:0] count;
		logic row_err;
		logic [31:0] up_cnt;
		logic [7:0] ref_idx;
		logic ref_read;
		logic refreshed;
		ssaa_bp_t bp;
		logic rvalid;
		logic [7:0] rdata;
	} ssaa_core_t;
	ssaa_core_t r_reg;
	ssaa_core_t r_next;
	logic [12:0] auto_addr;
	logic img_hit;
	logic img_in_we;
	logic img_out_we;
	logic [7:0] img_in_rdata;
	logic [7:0] img_out_rdata;

	ssaa_slot_addr u_slot_addr (
		.slot_idx(r_reg.slot),
		.module_class(module_class[r_reg.slot]),
		.start_addr(auto_addr)
	);

	ssaa_image u_image (
		.clock(clock),
		.rst_n(rst_n),
		.in_we(img_in_we),
		.in_addr(r_reg.ref_idx),
		.in_wdata(bp_rdata),
		.out_we(img_out_we),
		.out_addr(acc.addr[7:0]),
		.out_wdata(acc.wdata),
		.in_raddr(acc.addr[7:0]),
		.in_rdata(img_in_rdata),
		.out_raddr(r_reg.ref_idx),
		.out_rdata(img_out_rdata)
	);

	// image covers only the low range
	assign img_hit = acc.image && (acc.addr <= SSAA_IMG_TOP);
	// accesses wait for the address table
	assign acc_ready = (r_reg.st == ST_OPER) && r_reg.addr_ready && !cycle_done;
	assign img_out_we = acc_ready && acc.valid && acc.write && img_hit;
	assign img_in_we = (r_reg.st == ST_REFRESH) && r_reg.ref_read && bp_ready;

	// next-state logic of the whole sequencer
	always_comb begin
		r_next = r_reg;
		r_next.lever_s1 = mode_lever_run;
		r_next.lever_s2 = r_reg.lever_s1;
		r_next.batt_s1 = battery_charged;
		r_next.batt_s2 = r_reg.batt_s1;
		r_next.backup_s1 = backup_intact;
		r_next.backup_s2 = r_reg.backup_s1;
		r_next.lever_prev = r_reg.lever_s2;
		r_next.ovr = 1'b0;
		r_next.copy_card = 1'b0;
		r_next.copy_prot = 1'b0;
		r_next.diag = 1'b0;
		r_next.rvalid = 1'b0;
		r_next.refreshed = 1'b0;
		// fault held until 30 s of full battery
		if (r_reg.bat_fault && r_reg.st != ST_SETTLE) begin
			if (!r_reg.batt_s2) begin
				r_next.up_cnt = 32'h0;
			end else if (r_reg.up_cnt >= BAT_CLEAR_CYCLES - 32'h1) begin
				r_next.bat_fault = 1'b0;
				r_next.up_cnt = 32'h0;
				r_next.diag = 1'b1;
				r_next.diag_code = SSAA_DIAG_BAT_CLEARED;
			end else begin
				r_next.up_cnt = r_reg.up_cnt + 32'h1;
			end
		end
		case (r_reg.st)
			ST_SETTLE: begin
				// strap caught once, pins given time to pass the synchronisers
				if (r_reg.settle == 2'h0) begin
					r_next.fault_strap = battery_fault_stored;
				end
				r_next.settle = r_reg.settle + 2'h1;
				if (r_reg.settle == SSAA_SETTLE_CYC) begin
					r_next.st = ST_EVAL;
				end
			end
			ST_EVAL: begin
				// short power cycle repeats the reset
				if (!r_reg.backup_s2 || r_reg.fault_strap) begin
					r_next.unbuffered = 1'b1;
					r_next.bat_fault = 1'b1;
					r_next.st = ST_OVR;
				end else begin
					r_next.st = ST_ALLOC;
				end
			end
			ST_OVR: begin
				r_next.ovr = 1'b1;
				r_next.st = ST_COPY;
			end
			ST_COPY: begin
				if (r_reg.copy_card || r_reg.copy_prot) begin
					if (copy_done) begin
						r_next.prog = 1'b1;
						r_next.st = ST_ALLOC;
					end else begin
						r_next.copy_card = r_reg.copy_card;
						r_next.copy_prot = r_reg.copy_prot;
					end
				end else if (card_present) begin
					r_next.copy_card = 1'b1;
				end else if (protected_present) begin
					r_next.copy_prot = 1'b1;
				end else begin
					r_next.st = ST_ALLOC;
				end
			end
			ST_ALLOC: begin
				r_next.auto = !hw_config_present;
				r_next.addr_tab[r_reg.slot] = hw_config_present ? hw_addr_table[r_reg.slot] : auto_addr;
				if (module_class[r_reg.slot] != SSAA_CLS_EMPTY) begin
					r_next.count = r_reg.count + 6'h1;
				end
				r_next.slot = r_reg.slot + 5'h1;
				if (r_reg.slot == 5'(SSAA_SLOTS - 1)) begin
					r_next.st = ST_DECIDE;
				end
			end
			ST_DECIDE: begin
				// row limit without a row interface master
				// a plain row of 32 is accepted only under automatic allocation
				r_next.row_err = hw_config_present && !row_master_present && (r_reg.count > 6'(SSAA_ROW_MAX));
				r_next.addr_ready = 1'b1;
				if (r_reg.unbuffered) begin
					// handler needed for RUN, event logged
					r_next.run = r_reg.lever_s2 && fault_handler_present;
					r_next.diag = 1'b1;
					r_next.diag_code = SSAA_DIAG_UNBUF_PON;
				end else begin
					// retained program only with a valid configuration
					r_next.run = r_reg.lever_s2;
					r_next.prog = config_valid;
				end
				r_next.st = ST_OPER;
			end
			ST_OPER: begin
				// STOP to RUN keeps whatever program state is held
				if (!r_reg.lever_s2) begin
					r_next.run = 1'b0;
				end else if (!r_reg.lever_prev) begin
					r_next.run = 1'b1;
				end
				if (cycle_done) begin
					r_next.ref_idx = 8'h0;
					r_next.ref_read = 1'b0;
					r_next.st = ST_REFRESH;
				end else if (acc.valid && r_reg.addr_ready) begin
					if (img_hit) begin
						r_next.rvalid = 1'b1;
						r_next.rdata = acc.write ? r_reg.rdata : img_in_rdata;
					end else begin
						r_next.bp.valid = 1'b1;
						r_next.bp.write = acc.write;
						r_next.bp.addr = acc.addr;
						r_next.bp.wdata = acc.wdata;
						r_next.st = ST_DIRECT;
					end
				end
			end
			ST_DIRECT: begin
				if (bp_ready) begin
					r_next.bp.valid = 1'b0;
					r_next.rvalid = 1'b1;
					r_next.rdata = r_reg.bp.write ? r_reg.rdata : bp_rdata;
					r_next.st = ST_OPER;
				end
			end
			ST_REFRESH: begin
				// each byte: output image out first, then input image in
				if (!r_reg.bp.valid) begin
					r_next.bp.valid = 1'b1;
					r_next.bp.write = !r_reg.ref_read;
					r_next.bp.addr = {5'h00, r_reg.ref_idx};
					r_next.bp.wdata = img_out_rdata;
				end else if (bp_ready) begin
					r_next.bp.valid = 1'b0;
					r_next.ref_read = !r_reg.ref_read;
					if (r_reg.ref_read) begin
						r_next.ref_idx = r_reg.ref_idx + 8'h1;
						if (r_reg.ref_idx == 8'(SSAA_IMG_BYTES - 1)) begin
							r_next.refreshed = 1'b1;
							r_next.st = ST_OPER;
						end
					end
				end
			end
			default: begin
				r_next.st = ST_SETTLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign acc_rvalid = r_reg.rvalid;
	assign acc_rdata = r_reg.rdata;
	assign bp = r_reg.bp;
	assign run_mode = r_reg.run;
	assign program_loaded = r_reg.prog;
	assign battery_fault = r_reg.bat_fault;
	assign overall_reset = r_reg.ovr;
	assign copy_from_card = r_reg.copy_card;
	assign copy_protected = r_reg.copy_prot;
	assign diag_valid = r_reg.diag;
	assign diag_code = r_reg.diag_code;
	assign addr_ready = r_reg.addr_ready;
	assign auto_alloc = r_reg.auto;
	assign slot_addr = r_reg.addr_tab;
	assign module_count = r_reg.count;
	assign row_limit_error = r_reg.row_err;
	assign image_refreshed = r_reg.refreshed;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence eval_lost_s;
		r_reg.st == ST_EVAL && !r_reg.backup_s2;
	endsequence
	sequence ovr_then_copy_s;
		r_reg.ovr && r_reg.st == ST_COPY ##1 !r_reg.ovr;
	endsequence

	fault_on_loss_a: assert property (eval_lost_s |=> battery_fault ##1 ovr_then_copy_s)
		else $error("lost backup did not raise fault and reset");
	ovr_single_a: assert property (overall_reset |=> !overall_reset)
		else $error("overall reset longer than one cycle");
	ready_gate_a: assert property (!addr_ready |-> !acc_ready && !bp.valid && !acc_rvalid)
		else $error("access taken before addresses ready");
	dig_addr_a: assert property (r_reg.st == ST_ALLOC && !hw_config_present
		&& module_class[r_reg.slot] == SSAA_CLS_DIGITAL |=> slot_addr[$past(r_reg.slot)] == 13'($past(r_reg.slot) * 4))
		else $error("digital start address wrong");
	ana_addr_a: assert property (r_reg.st == ST_ALLOC && !hw_config_present
		&& module_class[r_reg.slot] == SSAA_CLS_ANALOG
		|=> slot_addr[$past(r_reg.slot)] == 13'($past(r_reg.slot) * 16 + 256))
		else $error("analog start address wrong");
	fault_clear_a: assert property ($fell(battery_fault) |-> $past(r_reg.up_cnt) == BAT_CLEAR_CYCLES - 32'h1)
		else $error("battery fault cleared early");
	handler_stop_a: assert property (r_reg.st == ST_DECIDE && r_reg.unbuffered && !fault_handler_present
		|=> !run_mode && diag_valid && diag_code == SSAA_DIAG_UNBUF_PON)
		else $error("unbuffered start without handler left STOP");
	lever_follow_a: assert property (r_reg.st == ST_DECIDE && !r_reg.unbuffered |=> run_mode == $past(r_reg.lever_s2))
		else $error("start-up mode differs from lever");
	refresh_start_a: assert property (r_reg.st == ST_OPER && cycle_done
		|=> r_reg.st == ST_REFRESH ##1 bp.valid && bp.write && bp.addr == 13'h0000)
		else $error("refresh did not start after cycle end");
endmodule // ssaa_startup

// *** ssaa_bp_model.sv ***
// behavioural model of the peripheral modules on the backplane bus
`timescale 1ns/10ps
module ssaa_bp_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic slow,
	input wire ssaa_pkg::ssaa_bp_t bp,
	output logic bp_ready,
	output logic [7:0] bp_rdata
);
	import ssaa_pkg::*;
	logic [7:0] in_mem [0:8191];
	logic [7:0] out_mem [0:8191];
	logic [1:0] wait_reg;
	logic [7:0] last_reg = 8'h00;
	// input and output bytes are separate spaces, so a refresh write never alters what is read back
	initial for (int i = 0; i < 8192; i++) begin
		in_mem[i] = 8'(i) ^ 8'hA5;
		out_mem[i] = 8'h00;
	end
	// slow mode stretches each request by three cycles
	assign bp_ready = bp.valid && (!slow || wait_reg == 2'h3);
	// released data line shows the inverse of the last value, not a stale copy
	assign bp_rdata = (bp_ready && !bp.write) ? in_mem[bp.addr] : ~last_reg;
	// wait counter, write port and idle data pattern
	always @(posedge clock) begin
		last_reg <= bp_rdata;
		if (!rst_n || !bp.valid || bp_ready) wait_reg <= 2'h0;
		else wait_reg <= wait_reg + 2'h1;
		if (bp_ready && bp.write) out_mem[bp.addr] <= bp.wdata;
	end
endmodule // ssaa_bp_model

// *** tb_top.sv ***
// self-checking testbench of the start-up sequencer and slot allocator
`timescale 1ns/10ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
	import ssaa_pkg::*;
	logic clock = 0, rst_n = 0, lever = 0, charged = 1, intact = 1, stored = 0, cfg = 0;
	logic card = 0, prot = 0, handler = 0, hwcfg = 0, rowm = 0, copy_done = 0, cycle_done = 0, slow = 0;
	ssaa_class_vec_t cls = '0;
	ssaa_table_t hw_tab = '0, slot_addr;
	ssaa_acc_t acc = '0;
	ssaa_bp_t bp;
	logic acc_ready, acc_rvalid, bp_ready, run_mode, program_loaded, battery_fault, overall_reset;
	logic copy_from_card, copy_protected, diag_valid, addr_ready, auto_alloc, row_limit_error, image_refreshed;
	logic [7:0] acc_rdata, bp_rdata, diag_code, last_diag, q;
	logic [5:0] module_count;
	int n_mismatch = 0, checks_done = 0, n_ovr = 0, cyc = 0;
	always #4 clock = ~clock;
	ssaa_startup #(.BAT_CLEAR_CYCLES(32'd50)) i_ssaa_startup (.clock(clock), .rst_n(rst_n),
		.mode_lever_run(lever), .battery_charged(charged), .backup_intact(intact), .battery_fault_stored(stored),
		.config_valid(cfg), .card_present(card), .protected_present(prot), .fault_handler_present(handler),
		.hw_config_present(hwcfg), .row_master_present(rowm), .copy_done(copy_done), .module_class(cls),
		.hw_addr_table(hw_tab), .cycle_done(cycle_done), .acc(acc), .acc_ready(acc_ready), .acc_rvalid(acc_rvalid),
		.acc_rdata(acc_rdata), .bp(bp), .bp_ready(bp_ready), .bp_rdata(bp_rdata), .run_mode(run_mode),
		.program_loaded(program_loaded), .battery_fault(battery_fault), .overall_reset(overall_reset),
		.copy_from_card(copy_from_card), .copy_protected(copy_protected), .diag_valid(diag_valid),
		.diag_code(diag_code), .addr_ready(addr_ready), .auto_alloc(auto_alloc), .slot_addr(slot_addr),
		.module_count(module_count), .row_limit_error(row_limit_error), .image_refreshed(image_refreshed));
	ssaa_bp_model i_ssaa_bp_model (.clock(clock), .rst_n(rst_n), .slow(slow), .bp(bp), .bp_ready(bp_ready),
		.bp_rdata(bp_rdata));
	// pulse outputs are counted here since tasks sample only at falling edges
	always @(posedge clock) begin
		cyc++;
		if (rst_n && overall_reset === 1'b1) n_ovr++;
		if (rst_n && diag_valid === 1'b1) last_diag = diag_code;
		if (cyc == 40000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// power cycle: hold reset five cycles, then release
	task automatic power_on();
		@(negedge clock);
		rst_n = 0;
		repeat (5) @(negedge clock);
		n_ovr = 0;
		last_diag = 8'h00;
		rst_n = 1;
	endtask
	task automatic wait_sig(ref logic s);
		for (int n = 0; n < 400 && s !== 1'b1; n++) @(negedge clock);
	endtask
	// one program access: hold the request until taken, then wait for the answer
	task automatic xfer(input logic img, input logic wr, input logic [12:0] a, input logic [7:0] d);
		int n;
		@(negedge clock);
		acc = '{1'b1, wr, img, a, d};
		// ready is looked at mid-cycle, so the request still stands at the rising edge that takes it
		for (n = 0; n < 400 && acc_ready !== 1'b1; n++) @(negedge clock);
		@(negedge clock);
		acc.valid = 1'b0;
		for (n = 0; n < 400 && acc_rvalid !== 1'b1; n++) @(negedge clock);
		`CHK(acc_rvalid, 1'b1)
		q = acc_rdata;
	endtask
	function automatic logic [12:0] exp_addr(int i, logic [2:0] c);
		return (c == SSAA_CLS_DIGITAL) ? 13'(4 * i) : 13'(16 * i + 256);
	endfunction
	task automatic t_boot_run();
		lever = 1; cfg = 1;
		cls[0] = SSAA_CLS_DIGITAL; cls[1] = SSAA_CLS_ANALOG; cls[2] = SSAA_CLS_FUNCTION;
		cls[3] = SSAA_CLS_COMM; cls[4] = SSAA_CLS_DIGITAL; cls[31] = SSAA_CLS_ANALOG;
		power_on();
		wait_sig(addr_ready);
		`CHK(addr_ready, 1'b1)
		`CHK(run_mode, 1'b1)
		`CHK(program_loaded, 1'b1)
		`CHK(auto_alloc, 1'b1)
		`CHK(module_count, 6'h06)
		`CHK({battery_fault, n_ovr}, 33'h0)
		for (int i = 0; i < 32; i++)
			if (cls[i] != SSAA_CLS_EMPTY) `CHK(slot_addr[i], exp_addr(i, cls[i]))
		$display("boot run done");
	endtask
	task automatic t_factory();
		lever = 0; cfg = 0;
		power_on();
		wait_sig(addr_ready);
		`CHK(run_mode, 1'b0)
		lever = 1;
		repeat (8) @(negedge clock);
		`CHK({run_mode, program_loaded}, 2'b10)
		$display("factory start done");
	endtask
	task automatic t_image();
		xfer(1, 1, 13'h007, 8'h3C);
		cycle_done = 1;
		@(negedge clock);
		cycle_done = 0;
		for (int n = 0; n < 3000 && image_refreshed !== 1'b1; n++) @(negedge clock);
		`CHK(image_refreshed, 1'b1)
		`CHK(i_ssaa_bp_model.out_mem[7], 8'h3C)
		xfer(1, 0, 13'h009, 8'h00);
		`CHK(q, 8'hAC)
		slow = 1;
		xfer(0, 1, 13'h12C, 8'h5A);
		`CHK(i_ssaa_bp_model.out_mem[13'h12C], 8'h5A)
		xfer(0, 0, 13'h12C, 8'h00);
		`CHK(q, 8'h89)
		xfer(0, 0, 13'h1FFF, 8'h00);
		`CHK(q, 8'h5A)
		slow = 0;
		$display("image and direct access done");
	endtask
	task automatic t_battery_lost();
		intact = 0; card = 1; handler = 1; charged = 0;
		power_on();
		wait_sig(copy_from_card);
		`CHK({battery_fault, copy_from_card, copy_protected}, 3'b110)
		`CHK(n_ovr, 1)
		copy_done = 1;
		@(negedge clock);
		copy_done = 0;
		wait_sig(addr_ready);
		`CHK({run_mode, diag_valid, diag_code}, {2'b11, SSAA_DIAG_UNBUF_PON})
		charged = 1;
		repeat (30) @(negedge clock);
		charged = 0;
		repeat (5) @(negedge clock);
		`CHK(battery_fault, 1'b1)
		charged = 1;
		repeat (80) @(negedge clock);
		`CHK({battery_fault, last_diag}, {1'b0, SSAA_DIAG_BAT_CLEARED})
		$display("battery loss done");
	endtask
	// short power cycle with fault kept: reset again, no card so protected blocks
	task automatic t_short_cycle();
		intact = 1; stored = 1; card = 0; prot = 1; handler = 0;
		power_on();
		wait_sig(copy_protected);
		`CHK({battery_fault, copy_protected, n_ovr}, {2'b11, 32'd1})
		copy_done = 1;
		@(negedge clock);
		copy_done = 0;
		stored = 0;
		wait_sig(addr_ready);
		`CHK({run_mode, diag_valid, diag_code}, {2'b01, SSAA_DIAG_UNBUF_PON})
		$display("short power cycle done");
	endtask
	task automatic t_hwcfg();
		hwcfg = 1;
		for (int i = 0; i < 9; i++) begin
			cls[i] = SSAA_CLS_DIGITAL;
			hw_tab[i] = 13'(32 * i + 17);
		end
		power_on();
		wait_sig(addr_ready);
		`CHK({auto_alloc, row_limit_error}, 2'b01)
		`CHK(slot_addr[8], 13'h0111)
		// installer fits a row interface master, so the long row is accepted
		rowm = 1;
		power_on();
		wait_sig(addr_ready);
		`CHK(row_limit_error, 1'b0)
		$display("hardware configuration done");
	endtask
	initial begin
		t_boot_run();
		t_image();
		t_factory();
		t_battery_lost();
		t_short_cycle();
		t_hwcfg();
		tally_and_finish();
	end
endmodule // tb_top
